// file: hw/front_panel_release_control.v
// Front panel and release controller: bar display views, keypad adjustment
// of voltage, frequency and ion balance, release sources, fault and signal
// outputs. Assumes an AHB-Lite master on ref_clk, raw keys and release pins
// from outside the clock domain, and firmware that reports supply state.
// How it works
// - Frequency view lights the one bar position of the stored frequency step.
// - In frequency view +/- moves one step along the nine frequencies.
// - Fault output high only while supply on and no error.
// - Signal output follows the condition picked by its mode.
// - Either hardware release pin alone grants hardware release.
// - With both enabled, hardware and software release sources must both grant.
// - Automatic option sets software release once boot is complete.
// - Release key toggles keypad software release when keypad option set.
// - Remote-held release cannot be cleared locally, only remotely.
// - Fieldbus commands set or clear release when that option is set.
// - Key lock ignores all keys; fieldbus failure clears the lock.
// - View key cycles voltage, frequency, pollution, balance with indicator.
// - In pollution view +/- selects the connection shown.
// - View changes on press and on hold repeat, never during setup.
// - Voltage setpoint moves in 100 V steps from 3.5 to 5.0 kV.
// - A +/- press in voltage view shows the setpoint at once.
// - Setpoint kept without confirm; no adjustment during setup.
// - Frequency kept without confirm; no change during setup.
// - In balance view +/- adjusts signed ion balance offset.
// - Balance bar lights centre, extending left negative, right positive.
// - Balance kept without confirm; no change during setup.
// - Bar has eleven positions, 1 at left to 11 at right.
`timescale 1ns/10ps
`default_nettype none
`include "panel_regs.vh"

module front_panel_release_control #(
  parameter REPEAT_CYC = `REPEAT_MS * `CLK_KHZ,
  parameter SHOW_CYC   = `SHOW_MS * `CLK_KHZ
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        keyPlusRaw,
  input  wire        keyMinusRaw,
  input  wire        barViewSelectKey,
  input  wire        releaseKeyRaw,
  input  wire        release1Raw,
  input  wire        release2Raw,
  input  wire        busFailRaw,
  output reg  [10:0] barLed,
  output reg         voltageViewIndicator,
  output reg         frequencyViewIndicator,
  output reg         pollutionViewIndicator,
  output reg         balanceViewIndicator,
  output reg  [3:0]  connIndicator,
  output wire        hvRelease,
  output reg         faultOut,
  output reg         signalOut
);

  // Bar positions lo..hi lit, positions counted from 0 at the left
  function [10:0] span;
    input [3:0] lo;
    input [3:0] hi;
    integer k;
    begin
      span = 11'h000;
      for (k = 0; k < `BAR_W; k = k + 1)
        if (k >= lo && k <= hi)
          span[k] = 1'b1;
    end
  endfunction

  // Thermometer of lvl lit positions, zero lights none
  function [10:0] thermo;
    input [3:0] lvl;
    begin
      if (lvl == 4'h0)
        thermo = 11'h000;
      else
        thermo = span(4'h0, lvl - 4'h1);
    end
  endfunction

  // Bus side state
  reg        wrPend_reg;
  reg        rdPend_reg;
  reg [7:0]  addr_reg;
  reg [7:0]  ctrl_reg;
  reg [11:0] state_reg;
  reg [15:0] poll_reg;
  reg [31:0] rdMux;
  wire       accept;
  wire       wrCtrl;
  wire       wrCmd;

  // Panel state
  reg [1:0]  view_reg;
  reg [3:0]  voltIdx_reg;
  reg [3:0]  freqIdx_reg;
  reg [3:0]  bal_reg;
  reg [1:0]  conn_reg;
  reg [27:0] showCnt_reg;
  reg        busA_reg;
  reg        busB_reg;
  reg        keyRel_reg;
  reg        remRel_reg;
  reg        canRel_reg;
  reg        ethRel_reg;
  reg        autoRel_reg;
  reg [10:0] barNext;
  reg [3:0]  connLvl;
  wire [3:0] press;
  wire       keysOn;
  wire       adjOn;
  wire       up;
  wire       down;
  wire       swGrant;
  wire [7:0] voltScaled;
  wire [12:0] setpointV;
  wire [31:0] showLoad;

  assign accept = hsel & hready & htrans[1];
  assign wrCtrl = wrPend_reg & (addr_reg == `OFS_CTRL);
  assign wrCmd  = wrPend_reg & (addr_reg == `OFS_CMD);

  // Writes are zero wait; reads take one wait state so a write just ahead
  // of them is already in the registers when the read data is formed.
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h00000000;
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      addr_reg   <= 8'h00;
    end
    else
    begin
      wrPend_reg <= accept & hwrite;
      rdPend_reg <= accept & ~hwrite;
      if (accept)
        addr_reg <= haddr[7:0];
      if (accept & ~hwrite)
        hreadyout <= 1'b0;
      else
        hreadyout <= 1'b1;
      if (rdPend_reg)
        hrdata <= rdMux;
    end
  end

  // Read decode; unmapped offsets and the command register read zero
  always @*
  begin
    rdMux = 32'h00000000;
    case (addr_reg)
      `OFS_CTRL:    rdMux[7:0]  = ctrl_reg;
      `OFS_STATE:   rdMux[11:0] = state_reg;
      `OFS_POLL:    rdMux[15:0] = poll_reg;
      `OFS_SETTING: rdMux[21:0] = {hvRelease, autoRel_reg, ethRel_reg, canRel_reg,
                                   remRel_reg, keyRel_reg, conn_reg, view_reg,
                                   bal_reg, freqIdx_reg, voltIdx_reg};
      `OFS_SETPT:   rdMux[12:0] = setpointV;
      `OFS_BAR:     rdMux[10:0] = barLed;
      default:      rdMux = 32'h00000000;
    endcase
  end

  // Fieldbus failure pin, two flops before use
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busA_reg <= 1'b0;
      busB_reg <= 1'b0;
    end
    else
    begin
      busA_reg <= busFailRaw;
      busB_reg <= busA_reg;
    end
  end

  // Configuration, firmware state and pollution levels
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_reg  <= `CTRL_RESET;
      state_reg <= `STATE_RESET;
      poll_reg  <= 16'h0000;
    end
    else
    begin
      if (wrCtrl)
        ctrl_reg <= hwdata[7:0];
      if (busB_reg)
        ctrl_reg[`CTRL_LOCK] <= 1'b0;
      if (wrPend_reg && addr_reg == `OFS_STATE)
        state_reg <= hwdata[11:0];
      if (wrPend_reg && addr_reg == `OFS_POLL)
        poll_reg <= hwdata[15:0];
    end
  end

  key_pulse #(
    .W        (4),
    .REP_CYC  (REPEAT_CYC),
    .REP_MASK (4'h7)
  ) u_keys (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .keyRaw     ({releaseKeyRaw, barViewSelectKey, keyMinusRaw, keyPlusRaw}),
    .pressPulse (press)
  );

  assign keysOn = ~ctrl_reg[`CTRL_LOCK];
  assign adjOn  = keysOn & ~state_reg[`ST_SETUP];
  assign up     = adjOn & press[0] & ~press[1];
  assign down   = adjOn & press[1] & ~press[0];

  // View selection and stored settings
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      view_reg    <= `VIEW_VOLT;
      voltIdx_reg <= `VOLT_RESET;
      freqIdx_reg <= `FREQ_RESET;
      bal_reg     <= 4'h0;
      conn_reg    <= 2'h0;
    end
    else
    begin
      if (adjOn & press[2])
        view_reg <= view_reg + 2'h1;
      case (view_reg)
        `VIEW_VOLT:
        begin
          if (up && voltIdx_reg != `VOLT_IDX_MAX)
            voltIdx_reg <= voltIdx_reg + 4'h1;
          else if (down && voltIdx_reg != 4'h0)
            voltIdx_reg <= voltIdx_reg - 4'h1;
        end
        `VIEW_FREQ:
        begin
          if (up && freqIdx_reg != `FREQ_IDX_MAX)
            freqIdx_reg <= freqIdx_reg + 4'h1;
          else if (down && freqIdx_reg != 4'h0)
            freqIdx_reg <= freqIdx_reg - 4'h1;
        end
        `VIEW_POLL:
        begin
          if (up && conn_reg != `CONN_MAX)
            conn_reg <= conn_reg + 2'h1;
          else if (down && conn_reg != 2'h0)
            conn_reg <= conn_reg - 2'h1;
        end
        `VIEW_BAL:
        begin
          if (up && bal_reg != `BAL_POS_MAX)
            bal_reg <= bal_reg + 4'h1;
          else if (down && bal_reg != `BAL_NEG_MAX)
            bal_reg <= bal_reg - 4'h1;
        end
        default:
          view_reg <= `VIEW_VOLT;
      endcase
    end
  end

  // Display time load, cut to the counter width on purpose
  assign showLoad = SHOW_CYC;

  // setpoint shown after a +/- press, for a while
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      showCnt_reg <= 28'h0000000;
    else if ((up | down) && view_reg == `VIEW_VOLT)
      showCnt_reg <= showLoad[27:0];
    else if (showCnt_reg != 28'h0000000)
      showCnt_reg <= showCnt_reg - 28'h0000001;
  end

  assign setpointV  = `VOLT_MIN_V + voltIdx_reg * `VOLT_STEP_V;
  // Sixteen setpoints spread over positions 0..10
  assign voltScaled = ({4'h0, voltIdx_reg} * 8'h0A) / 8'h0F;

  // Bar contents for the current view
  always @*
  begin
    connLvl = poll_reg[conn_reg * 4 +: 4];
    case (view_reg)
      `VIEW_VOLT:
        if (showCnt_reg != 28'h0000000)
          barNext = span(4'h0, voltScaled[3:0]);
        else
          barNext = thermo(state_reg[`ST_MEAS_LO +: 4]);
      `VIEW_FREQ: barNext = span(freqIdx_reg, freqIdx_reg);
      `VIEW_POLL: barNext = thermo(connLvl);
      `VIEW_BAL:
        if (bal_reg[3])
          barNext = span(`BAR_CENTRE + bal_reg, `BAR_CENTRE);
        else
          barNext = span(`BAR_CENTRE, `BAR_CENTRE + bal_reg);
      default: barNext = 11'h000;
    endcase
  end

  // eleven positions, bit 0 at the left
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      barLed                 <= 11'h000;
      voltageViewIndicator   <= 1'b0;
      frequencyViewIndicator <= 1'b0;
      pollutionViewIndicator <= 1'b0;
      balanceViewIndicator   <= 1'b0;
      connIndicator          <= 4'h0;
    end
    else
    begin
      barLed <= barNext;
      voltageViewIndicator   <= (view_reg == `VIEW_VOLT);
      frequencyViewIndicator <= (view_reg == `VIEW_FREQ);
      pollutionViewIndicator <= (view_reg == `VIEW_POLL);
      balanceViewIndicator   <= (view_reg == `VIEW_BAL);
      connIndicator <= (view_reg == `VIEW_POLL) ? (4'h1 << conn_reg) : 4'h0;
    end
  end

  // Software release sources; a set and clear together leaves it set
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      keyRel_reg  <= 1'b0;
      remRel_reg  <= 1'b0;
      canRel_reg  <= 1'b0;
      ethRel_reg  <= 1'b0;
      autoRel_reg <= 1'b0;
    end
    else
    begin
      autoRel_reg <= ctrl_reg[`CTRL_AUTO] & state_reg[`ST_BOOTED];
      if (keysOn && press[3] && ctrl_reg[`CTRL_KEYPAD])
        keyRel_reg <= ~keyRel_reg | remRel_reg;
      if (wrCmd && hwdata[`CMD_REM_SET])
        remRel_reg <= 1'b1;
      else if (wrCmd && hwdata[`CMD_REM_CLR])
        remRel_reg <= 1'b0;
      if (wrCmd && hwdata[`CMD_CAN_SET])
        canRel_reg <= 1'b1;
      else if (wrCmd && hwdata[`CMD_CAN_CLR])
        canRel_reg <= 1'b0;
      if (wrCmd && hwdata[`CMD_ETH_SET])
        ethRel_reg <= 1'b1;
      else if (wrCmd && hwdata[`CMD_ETH_CLR])
        ethRel_reg <= 1'b0;
    end
  end

  assign swGrant = autoRel_reg |
                   (ctrl_reg[`CTRL_KEYPAD] & (keyRel_reg | remRel_reg)) |
                   (ctrl_reg[`CTRL_CAN] & canRel_reg) |
                   (ctrl_reg[`CTRL_ETH] & ethRel_reg);

  release_combiner u_release (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .release1Raw (release1Raw),
    .release2Raw (release2Raw),
    .hwEn        (ctrl_reg[`CTRL_HWEN]),
    .swEn        (|ctrl_reg[`CTRL_ETH:`CTRL_AUTO]),
    .swGrant     (swGrant),
    .hvRelease   (hvRelease)
  );

  // Status outputs
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      faultOut  <= 1'b0;
      signalOut <= 1'b0;
    end
    else
    begin
      // healthy when on and error free
      faultOut <= state_reg[`ST_SUPPLY] & ~state_reg[`ST_ERROR];
      case (ctrl_reg[`CTRL_MODE_LO +: 2])
        `MODE_HV:   signalOut <= state_reg[`ST_HVON];
        `MODE_WARN: signalOut <= state_reg[`ST_WARN];
        `MODE_POLL: signalOut <= state_reg[`ST_POLL];
        default:    signalOut <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: hw/panel_regs.vh
// Register map, field positions, value ranges and timing for the front panel
// and release controller. Definitions only, no logic.
`ifndef PANEL_REGS_VH
`define PANEL_REGS_VH

// Byte offsets on the AHB-Lite bus (low address bits)
`define OFS_CTRL    8'h00
`define OFS_STATE   8'h04
`define OFS_CMD     8'h08
`define OFS_POLL    8'h0C
`define OFS_SETTING 8'h10
`define OFS_SETPT   8'h14
`define OFS_BAR     8'h18

// CTRL fields
`define CTRL_LOCK    0
`define CTRL_HWEN    1
`define CTRL_AUTO    2
`define CTRL_KEYPAD  3
`define CTRL_CAN     4
`define CTRL_ETH     5
`define CTRL_MODE_LO 6
`define CTRL_RESET   8'h08

// STATE fields, reported by the supply firmware
`define ST_SUPPLY  0
`define ST_ERROR   1
`define ST_HVON    2
`define ST_WARN    3
`define ST_POLL    4
`define ST_SETUP   5
`define ST_BOOTED  6
`define ST_MEAS_LO 8
`define STATE_RESET 12'h000

// CMD fields, write-one pulses
`define CMD_CAN_SET 0
`define CMD_CAN_CLR 1
`define CMD_ETH_SET 2
`define CMD_ETH_CLR 3
`define CMD_REM_SET 4
`define CMD_REM_CLR 5

// Signal output modes
`define MODE_HV   2'h0
`define MODE_WARN 2'h1
`define MODE_POLL 2'h2

// Bar views, in key order
`define VIEW_VOLT 2'h0
`define VIEW_FREQ 2'h1
`define VIEW_POLL 2'h2
`define VIEW_BAL  2'h3

// Value ranges
`define BAR_W        11
`define BAR_CENTRE   4'h5
`define BAR_TOP      4'hA
`define VOLT_MIN_V   13'h0DAC
`define VOLT_STEP_V  13'h0064
`define VOLT_IDX_MAX 4'hF
`define VOLT_RESET   4'hF
`define FREQ_IDX_MAX 4'h8
`define FREQ_RESET   4'h4
`define BAL_POS_MAX  4'h5
`define BAL_NEG_MAX  4'hB
`define CONN_MAX     2'h3

// Timing
`define CLK_KHZ   125000
`define REPEAT_MS 300
`define SHOW_MS   2000

`endif

// file: hw/key_pulse.v
// Key front end: synchronises raw key levels and emits one-cycle press pulses.
// Keys marked in REP_MASK repeat every REP_CYC cycles while held.
`timescale 1ns/10ps
`default_nettype none

module key_pulse #(
  parameter W       = 4,
  parameter REP_CYC = 37500000,
  parameter [W-1:0] REP_MASK = {W{1'b1}}
) (
  input  wire         ref_clk,
  input  wire         sys_rst,
  input  wire [W-1:0] keyRaw,
  output reg  [W-1:0] pressPulse
);

  reg [W-1:0] syncA_reg;
  reg [W-1:0] syncB_reg;
  reg [W-1:0] prev_reg;
  reg [27:0]  holdCnt_reg [0:W-1];
  integer     i;

  // Two flops per key; only the second one is looked at
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      syncA_reg  <= {W{1'b0}};
      syncB_reg  <= {W{1'b0}};
      prev_reg   <= {W{1'b0}};
      pressPulse <= {W{1'b0}};
      for (i = 0; i < W; i = i + 1)
        holdCnt_reg[i] <= 28'h0000000;
    end
    else
    begin
      syncA_reg <= keyRaw;
      syncB_reg <= syncA_reg;
      prev_reg  <= syncB_reg;
      for (i = 0; i < W; i = i + 1)
      begin
        // Held keys restart the counter after each repeat pulse
        if (!syncB_reg[i] || !prev_reg[i] || holdCnt_reg[i] == REP_CYC - 1)
          holdCnt_reg[i] <= 28'h0000000;
        else
          holdCnt_reg[i] <= holdCnt_reg[i] + 28'h0000001;
        pressPulse[i] <= (syncB_reg[i] & ~prev_reg[i]) |
                         (REP_MASK[i] & syncB_reg[i] & prev_reg[i] &
                          (holdCnt_reg[i] == REP_CYC - 1));
      end
    end
  end

endmodule

`default_nettype wire

// file: hw/release_combiner.v
// Merges the two hardware release pins and the software grant into one
// high-voltage release. Pins are asynchronous and are synchronised here.
`timescale 1ns/10ps
`default_nettype none

module release_combiner (
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire release1Raw,
  input  wire release2Raw,
  input  wire hwEn,
  input  wire swEn,
  input  wire swGrant,
  output reg  hvRelease
);

  reg [1:0] syncA_reg;
  reg [1:0] syncB_reg;
  wire      hwGrant;

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      syncA_reg <= 2'h0;
      syncB_reg <= 2'h0;
    end
    else
    begin
      syncA_reg <= {release2Raw, release1Raw};
      syncB_reg <= syncA_reg;
    end
  end

  assign hwGrant = syncB_reg[0] | syncB_reg[1];

  // sources combined by AND, not independently; each enabled kind must grant
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      hvRelease <= 1'b0;
    else
      hvRelease <= (hwEn | swEn) & (~hwEn | hwGrant) & (~swEn | swGrant);
  end

endmodule

`default_nettype wire

// file: verif/panel_keypad_model.sv
// Operator keypad and release pin model for the panel controller.
// Assumes ref_clk from the bench; every change follows a rising edge.
`timescale 1ns/10ps
`default_nettype none

module panel_keypad_model (
  input  wire logic  ref_clk,
  output logic [3:0] keys,
  output logic [2:0] pins
);
  // Released keys and pins read low, as an open contact does
  initial keys = 4'h0;
  initial pins = 3'h0;

  // Key bits: 0 plus, 1 minus, 2 view, 3 release; n is the hold in cycles,
  // below repeat time by default, longer to exercise the hold repeat
  task automatic press(input int k, input int n = 4);
    @(posedge ref_clk);
    keys[k] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    keys[k] <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask

  // pins switched together, all three from v at once
  // Bits: 0 first release pin, 1 second, 2 fieldbus failure
  task automatic setPins(input logic [2:0] v);
    @(posedge ref_clk);
    pins <= v;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// file: verif/front_panel_release_control_monitor.sv
// Port checker for the panel controller: bus timing, views and bar.
// Assumes hready is fed from hreadyout by the surrounding bench.
`timescale 1ns/10ps
`default_nettype none

module front_panel_release_control_monitor (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        barViewSelectKey,
  input wire logic [10:0] barLed,
  input wire logic        voltageViewIndicator,
  input wire logic        frequencyViewIndicator,
  input wire logic        pollutionViewIndicator,
  input wire logic        balanceViewIndicator,
  input wire logic [3:0]  connIndicator
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  wire [3:0] ind = {balanceViewIndicator, pollutionViewIndicator,
                    frequencyViewIndicator, voltageViewIndicator};

  // Bus request and answer steps, and an idle view key
  sequence req_taken;
    hsel && hready && htrans[1] && hreadyout;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence key_idle;
    !barViewSelectKey [*6];
  endsequence

  a_read_wait: assert property (req_taken and !hwrite |=> one_wait)
    else $error("read did not take exactly one wait cycle");
  a_write_nowait: assert property (req_taken and hwrite |=> hreadyout)
    else $error("write inserted a wait cycle");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_one_view: assert property (!$past(sys_rst) |-> $onehot(ind))
    else $error("view indicators not one-hot");
  a_view_order: assert property ($rose(frequencyViewIndicator) |-> $past(ind) == 4'h1)
    else $error("frequency view not entered from voltage view");
  a_view_hold: assert property (key_idle |-> $stable(ind))
    else $error("view changed without a key");
  a_freq_bar: assert property (frequencyViewIndicator |-> $onehot(barLed) && !barLed[10:9])
    else $error("frequency bar not a single position 1..9");
  a_bal_centre: assert property (balanceViewIndicator |-> barLed[5])
    else $error("balance bar centre dark");
  a_conn_only: assert property (!pollutionViewIndicator |-> connIndicator == 4'h0)
    else $error("connection lit outside pollution view");
endmodule

bind front_panel_release_control front_panel_release_control_monitor mon_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .barViewSelectKey(barViewSelectKey), .barLed(barLed),
  .voltageViewIndicator(voltageViewIndicator),
  .frequencyViewIndicator(frequencyViewIndicator),
  .pollutionViewIndicator(pollutionViewIndicator),
  .balanceViewIndicator(balanceViewIndicator), .connIndicator(connIndicator));
`default_nettype wire

// file: verif/front_panel_release_control_bench.sv
// Self-checking bench for the panel controller: AHB-Lite master, keypad model.
// Assumes short key repeat and setpoint display counts set below.
`timescale 1ns/10ps
`default_nettype none
`include "panel_regs.vh"

module front_panel_release_control_bench;
  logic        ref_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic        hvRelease, faultOut, signalOut;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [10:0] barLed;
  logic [3:0]  keys, connIndicator, ind;
  logic [2:0]  pins;
  int          fail_count, checks_done, cycles;

  panel_keypad_model pad_u (.ref_clk(ref_clk), .keys(keys), .pins(pins));

  front_panel_release_control #(.REPEAT_CYC(20), .SHOW_CYC(50)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .keyPlusRaw(keys[0]), .keyMinusRaw(keys[1]), .barViewSelectKey(keys[2]),
    .releaseKeyRaw(keys[3]), .release1Raw(pins[0]), .release2Raw(pins[1]),
    .busFailRaw(pins[2]), .barLed(barLed), .voltageViewIndicator(ind[0]),
    .frequencyViewIndicator(ind[1]), .pollutionViewIndicator(ind[2]),
    .balanceViewIndicator(ind[3]), .connIndicator(connIndicator),
    .hvRelease(hvRelease), .faultOut(faultOut), .signalOut(signalOut));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Single transfer: address phase, then data phase, each held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    // Upper address and data bits carry inverted copies; the design ignores them
    haddr <= {~a, ~a, ~a, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {~d[15:0], d[15:0]};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    check(rd, e);
  endtask

  task automatic reset_values;
    rdchk(`OFS_CTRL, 32'h00000008);
    rdchk(`OFS_SETTING, 32'h0000004F);
    rdchk(8'h1C, 32'h00000000);
    rdchk(8'hE0, 32'h00000000);
  endtask

  task automatic views;
    for (int i = 1; i <= 4; i++)
    begin
      pad_u.press(2);
      check(ind, 4'h1 << (i % 4));
    end
    // A long hold gives the press step plus one repeat step
    pad_u.press(2, 30);
    check(ind, 4'h4);
    pad_u.press(2, 30);
    check(ind, 4'h1);
    bus(1'b1, `OFS_CTRL, 32'h00000009);
    pad_u.press(2);
    check(ind, 4'h1);
    pad_u.setPins(3'h4);
    rdchk(`OFS_CTRL, 32'h00000008);
    pad_u.setPins(3'h0);
    bus(1'b1, `OFS_STATE, 32'h00000020);
    pad_u.press(2);
    check(ind, 4'h1);
    bus(1'b1, `OFS_STATE, 32'h00000000);
  endtask

  task automatic volt;
    bus(1'b1, `OFS_STATE, 32'h00000700);
    check(barLed, 11'h07F);
    pad_u.press(1);
    check(barLed, 11'h3FF);
    rdchk(`OFS_SETPT, 32'h00001324);
    pad_u.press(0);
    pad_u.press(0);
    rdchk(`OFS_SETPT, 32'h00001388);
    bus(1'b1, `OFS_STATE, 32'h00000020);
    pad_u.press(1);
    rdchk(`OFS_SETPT, 32'h00001388);
    bus(1'b1, `OFS_STATE, 32'h00000000);
  endtask

  // Steps past both ends of the nine-entry table
  task automatic freq;
    int idx;
    idx = 4;
    pad_u.press(2);
    for (int i = 0; i < 14; i++)
    begin
      pad_u.press(i < 5 ? 0 : 1);
      idx = (i < 5) ? (idx == 8 ? 8 : idx + 1) : (idx == 0 ? 0 : idx - 1);
      check(barLed, 11'h001 << idx);
    end
    bus(1'b1, `OFS_STATE, 32'h00000020);
    pad_u.press(0);
    check(barLed, 11'h001);
    bus(1'b1, `OFS_STATE, 32'h00000000);
  endtask

  task automatic poll_bal;
    pad_u.press(2);
    bus(1'b1, `OFS_POLL, 32'h0000FA30);
    pad_u.press(0);
    check(connIndicator, 4'h2);
    check(barLed, 11'h007);
    pad_u.press(1);
    pad_u.press(1);
    check(connIndicator, 4'h1);
    pad_u.press(2);
    repeat (6) pad_u.press(0);
    check(barLed, 11'h7E0);
    repeat (11) pad_u.press(1);
    check(barLed, 11'h03F);
    repeat (5) pad_u.press(0);
    check(barLed, 11'h020);
    pad_u.press(2);
  endtask

  task automatic releases;
    logic [7:0] opt [2] = '{8'h10, 8'h20};
    bus(1'b1, `OFS_CTRL, 32'h00000002);
    pad_u.setPins(3'h1);
    check(hvRelease, 1'b1);
    pad_u.setPins(3'h2);
    check(hvRelease, 1'b1);
    pad_u.setPins(3'h0);
    check(hvRelease, 1'b0);
    bus(1'b1, `OFS_CTRL, 32'h00000008);
    pad_u.press(3);
    check(hvRelease, 1'b1);
    bus(1'b1, `OFS_CMD, 32'h00000010);
    pad_u.press(3);
    check(hvRelease, 1'b1);
    bus(1'b1, `OFS_CMD, 32'h00000020);
    pad_u.press(3);
    check(hvRelease, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      bus(1'b1, `OFS_CTRL, {24'h000000, opt[j]});
      bus(1'b1, `OFS_CMD, 32'h00000001 << (2 * j));
      check(hvRelease, 1'b1);
      bus(1'b1, `OFS_CMD, 32'h00000002 << (2 * j));
      check(hvRelease, 1'b0);
    end
    bus(1'b1, `OFS_CTRL, 32'h00000004);
    check(hvRelease, 1'b0);
    bus(1'b1, `OFS_STATE, 32'h00000040);
    // Boot flag passes one extra register stage before the release
    @(posedge ref_clk);
    check(hvRelease, 1'b1);
    bus(1'b1, `OFS_CTRL, 32'h00000012);
    bus(1'b1, `OFS_CMD, 32'h00000001);
    check(hvRelease, 1'b0);
    pad_u.setPins(3'h1);
    check(hvRelease, 1'b1);
    pad_u.setPins(3'h0);
  endtask

  // Mode, state and expected {fault, signal} per line
  task automatic outputs;
    logic [7:0] ct [7] = '{8'h08, 8'h08, 8'h08, 8'h48, 8'h48, 8'h88, 8'hC8};
    logic [7:0] st [7] = '{8'h01, 8'h05, 8'h03, 8'h08, 8'h04, 8'h10, 8'h1C};
    logic [1:0] ex [7] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, `OFS_CTRL, {24'h000000, ct[i]});
      bus(1'b1, `OFS_STATE, {24'h000000, st[i]});
      check({faultOut, signalOut}, ex[i]);
    end
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Cuts a hang short well above the expected run length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      print_verdict;
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    reset_values;
    views;
    volt;
    freq;
    poll_bal;
    releases;
    outputs;
    print_verdict;
  end
endmodule
`default_nettype wire
